// file: logic/qfd_regs.svh
`ifndef QFD_REGS_SVH
`define QFD_REGS_SVH
// ****************************************
// opcodes
// ****************************************
`define QFD_OP_WRITE_ENABLE_COMMAND      8'h06
`define QFD_OP_WRDI      8'h04
`define QFD_OP_VWREN     8'h50
`define QFD_OP_BLK_LOCK  8'h36
`define QFD_OP_BLK_ULK   8'h39
`define QFD_OP_BLK_RD    8'h3D
`define QFD_OP_GLOCK     8'h7E
`define QFD_OP_GULK      8'h98
`define QFD_OP_RDSR0     8'h05
`define QFD_OP_RDSR1     8'h35
`define QFD_OP_RDCR      8'h15
`define QFD_OP_WRSR      8'h01
`define QFD_OP_WRSR1     8'h31
`define QFD_OP_WRCR      8'h11
`define QFD_OP_PGER      8'h81
`define QFD_OP_SECER     8'h20
`define QFD_OP_BE32      8'h52
`define QFD_OP_BE64      8'hD8
`define QFD_OP_BUFCLR    8'h9E
`define QFD_OP_BUFLD     8'h9A
`define QFD_OP_BUFRD     8'h9B
`define QFD_OP_BUFWR     8'h9C
`define QFD_OP_BUFPP     8'h9D
`define QFD_OP_DPD       8'hB9
`define QFD_OP_RELDPD    8'hAB
`define QFD_OP_SETRP     8'hC0
`define QFD_OP_FRD       8'h0B
`define QFD_OP_WRAPRD    8'h0C
`define QFD_OP_QIORD     8'hEB
`define QFD_OP_RDID      8'h9F
`define QFD_OP_EXITQ     8'hFF
`define QFD_OP_RSTEN     8'h66
`define QFD_OP_RST       8'h99
`define QFD_OP_DFRD      8'h0D
`define QFD_OP_D2RD      8'hBD
`define QFD_OP_DWRAP     8'h0E
`define QFD_OP_D4RD      8'hED
// ****************************************
// framing counts (address in bytes, dummy in link clocks) and reset values
// ****************************************
`define QFD_ADDR_BYTES   3
`define QFD_DMY_DFRD     6'd6
`define QFD_DMY_D2RD     6'd6
`define QFD_DMY_DQPI     6'd8
`define QFD_DMY_BUFRD    6'd2
`define QFD_CFG_RESET    8'h00
`define QFD_RDP_RESET    8'h00
`endif

// file: logic/qfd_pkg.sv
package qfd_pkg;
  // framing phase of one chip-select frame
  typedef enum logic [2:0] {
    QFD_OPC  = 3'b000,
    QFD_ADR  = 3'b001,
    QFD_DMY  = 3'b011,
    QFD_DAT  = 3'b010,
    QFD_IGN  = 3'b110
  } qfd_phase_e;
  // decoded framing of an opcode
  typedef struct packed {
    logic       known;   // opcode is served
    logic       hasAddr; // three address bytes follow
    logic       isRead;  // device drives data
    logic       isWrite; // host sends data
    logic [1:0] lanes;   // 0 one, 1 two, 2 four lines for data
    logic       dtr;     // data on both edges
  } qfd_frame_s;
  // pulses toward the core, at most one per finished command
  typedef struct packed {
    logic       welSet;
    logic       welClr;
    logic       volArm;
    logic       blkLock;
    logic       blkUnlock;
    logic       globLock;
    logic       globUnlock;
    logic       eraseReq;
    logic       bufClear;
    logic       bufLoad;
    logic       bufProg;
    logic       dpdEnter;
    logic       dpdLeave;
    logic       quadExit;
    logic       softReset;
  } qfd_evt_s;
endpackage

// file: logic/qfd_decoder.sv
`timescale 1ns/1ps
`include "qfd_regs.svh"
// Summary of operation
// - quad 06h sets, 04h clears write latch
// - quad 50h arms volatile status write
// - 36h 39h 3Dh take three address bytes
// - 7Eh locks all, 98h unlocks all
// - 05h 35h 15h return one register byte
// - 01h takes one or two, 31h one
// - 11h writes one configuration byte
// - erase opcodes take three address bytes
// - 9Eh clears buffer, 9Ah loads buffer
// - 9Bh address plus dummy, 9Ch writes
// - 9Dh programs buffer to addressed page
// - B9h enters deep power-down
// - ABh leaves power-down, returns id byte
// - C0h sets read dummy and wrap
// - 0Bh address, 8 dummy (selectable in quad), streams data
// - 0Ch wrapped burst read, selectable dummy
// - EBh quad read, selectable dummy, unbounded
// - 9Fh returns maker then two device bytes
// - quad FFh leaves quad mode
// - double rate 0Dh six, BDh 2+4 dummy
// - double rate quad 0Eh 0Dh 8, EDh 1+7
// - two-line data: even bits on IO0
// - quad mode moves nibbles, upper first
module qfd_decoder #(
  parameter logic [7:0]  MAKER_ID = 8'h5A,   // arbitrary value
  parameter logic [15:0] DEV_ID   = 16'h1234, // arbitrary value
  parameter logic [7:0]  ELEC_ID  = 8'hA5    // arbitrary value
) (
  input  wire logic             clk,         // core clock
  input  wire logic             reset,       // sync reset, high
  input  wire logic             linkClk,     // serial flash clock
  input  wire logic             csN,         // chip select, low
  input  wire logic [3:0]       ioIn,        // io pins in
  output logic      [3:0]       ioOut,       // io pins out
  output logic      [3:0]       ioOe,        // io enables
  input  wire logic [15:0]      statusIn,    // core status bits
  output logic                  writeEnableLatch, // write latch
  output logic                  quadMode,    // four wire mode
  output logic                  volatileArm, // volatile write armed
  output logic      [15:0]      statusWr,    // status write value
  output logic                  statusWrVal, // status write pulse
  output logic                  statusWrHi,  // only upper byte
  output logic      [7:0]       configReg,   // configuration byte
  output logic      [7:0]       readParam,   // dummy and wrap
  output logic      [23:0]      cmdAddr,     // address of command
  output qfd_pkg::qfd_evt_s     evt,         // command pulses
  input  wire logic             enterQuad    // core asks quad mode
);
  // ****************************************
  // link domain
  // ****************************************
  qfd_pkg::qfd_phase_e phase;                // frame phase
  logic [7:0]          opc;                  // opcode shift
  logic [7:0]          dbyte;                // data shift
  logic [3:0]          bitCnt;               // clocks within byte
  logic [1:0]          byteCnt;              // address byte count
  logic [5:0]          dmyCnt;               // dummy clocks left
  logic [1:0]          dataCnt;              // data bytes seen
  logic [23:0]         addr;                 // address shift
  logic [7:0]          outByte;              // byte being sent
  logic                rstArmed;             // 66h seen last
  logic                cmdValid;             // frame ended on a command
  logic [7:0]          cmdOpc;               // opcode held for core
  logic [15:0]         cmdData;              // data held for core
  logic [1:0]          cmdCnt;               // data count held
  qfd_pkg::qfd_frame_s nextFr;               // frame of next opcode
  logic [15:0]         stSync1, stSync2;     // status in link clock

  // per-opcode framing, shared by both clock domains
  function automatic qfd_pkg::qfd_frame_s frame(input logic [7:0] o,
                                                input logic q);
    qfd_pkg::qfd_frame_s f;
    f = '0;
    unique case (o)
      `QFD_OP_WRITE_ENABLE_COMMAND, `QFD_OP_WRDI, `QFD_OP_VWREN, `QFD_OP_GLOCK,
      `QFD_OP_GULK, `QFD_OP_BUFCLR, `QFD_OP_DPD, `QFD_OP_RSTEN,
      `QFD_OP_RST: f.known = 1'b1;
      `QFD_OP_BLK_LOCK, `QFD_OP_BLK_ULK, `QFD_OP_BLK_RD,
      `QFD_OP_PGER, `QFD_OP_SECER, `QFD_OP_BE32, `QFD_OP_BE64,
      `QFD_OP_BUFLD, `QFD_OP_BUFPP: begin
        f.known = 1'b1;
        f.hasAddr = 1'b1;
      end
      `QFD_OP_RDSR0, `QFD_OP_RDSR1, `QFD_OP_RDCR, `QFD_OP_RDID: begin
        f.known = 1'b1;
        f.isRead = 1'b1;
      end
      `QFD_OP_WRSR, `QFD_OP_WRSR1, `QFD_OP_WRCR, `QFD_OP_SETRP: begin
        f.known = 1'b1;
        f.isWrite = 1'b1;
      end
      `QFD_OP_BUFWR: begin
        f.known = 1'b1;
        f.hasAddr = 1'b1;
        f.isWrite = 1'b1;
      end
      `QFD_OP_RELDPD, `QFD_OP_BUFRD, `QFD_OP_FRD, `QFD_OP_WRAPRD,
      `QFD_OP_QIORD: begin
        f.known = 1'b1;
        f.hasAddr = 1'b1;
        f.isRead = 1'b1;
        if (o == `QFD_OP_QIORD) begin
          f.lanes = 2'd2;
        end
      end
      `QFD_OP_EXITQ: f.known = q;
      `QFD_OP_DFRD, `QFD_OP_D2RD, `QFD_OP_DWRAP, `QFD_OP_D4RD: begin
        f.known = (o != `QFD_OP_DWRAP) | q;
        f.hasAddr = 1'b1;
        f.isRead = 1'b1;
        f.dtr = 1'b1;
        f.lanes = (o == `QFD_OP_D2RD) ? 2'd1 :
                  (o == `QFD_OP_D4RD) ? 2'd2 : 2'd0;
      end
      default: f = '0;
    endcase
    if (q) begin
      f.lanes = 2'd2;
    end
    return f;
  endfunction

  // dummy clocks for a read: C0h bits 5:4 pick 4/6/8/10 clocks
  function automatic logic [5:0] dummyOf(input logic [7:0] o,
                                         input logic q,
                                         input logic [7:0] rp);
    if (o == `QFD_OP_DFRD || o == `QFD_OP_DWRAP || o == `QFD_OP_D4RD)
      return q ? `QFD_DMY_DQPI : `QFD_DMY_DFRD;
    if (o == `QFD_OP_D2RD)
      return `QFD_DMY_D2RD;
    if (o == `QFD_OP_BUFRD)
      return q ? `QFD_DMY_BUFRD : 6'd8;
    if (o == `QFD_OP_FRD && !q)
      return 6'd8;
    if (o == `QFD_OP_FRD || o == `QFD_OP_WRAPRD || o == `QFD_OP_QIORD)
      return {3'b000, rp[5:4], 1'b0} + 6'd4;
    return 6'd0;
  endfunction

  // slow signals into the link domain
  always_ff @(posedge linkClk) begin
    stSync1 <= statusIn;
    stSync2 <= stSync1;
  end

  qfd_pkg::qfd_frame_s fr;                   // frame of current opcode
  logic                quadLk;               // synchronised quad mode
  logic [7:0]          rpLk;                 // read parameters (static)
  logic [7:0]          nextOpc;              // opcode after this clock
  assign rpLk    = readParam;
  assign fr      = frame(opc, quadLk);
  assign nextOpc = quadLk ? {opc[3:0], ioIn} : {opc[6:0], ioIn[0]};
  assign nextFr  = frame(nextOpc, quadLk);
  // quad mode only moves between frames; a linkClk copy would lag a frame
  always_ff @(negedge csN) quadLk <= quadMode;

  // framing sequencer; chip select restarts a frame
  always_ff @(posedge linkClk or posedge csN) begin
    if (csN) begin
      phase   <= qfd_pkg::QFD_OPC;
      bitCnt  <= 4'd0;
      byteCnt <= 2'd0;
      dataCnt <= 2'd0;
      dmyCnt  <= 6'd0;
    end else begin
      bitCnt <= bitCnt + 4'd1;
      unique case (phase)
        qfd_pkg::QFD_OPC: begin
          opc <= nextOpc;
          if (bitCnt == (quadLk ? 4'd1 : 4'd7)) begin
            bitCnt <= 4'd0;
            phase <= !nextFr.known  ? qfd_pkg::QFD_IGN
                   : nextFr.hasAddr ? qfd_pkg::QFD_ADR : qfd_pkg::QFD_DAT;
          end
        end
        qfd_pkg::QFD_ADR: begin
          addr <= quadLk || fr.lanes == 2'd2 ? {addr[19:0], ioIn}
                : {addr[22:0], ioIn[0]};
          if (bitCnt == ((quadLk || fr.lanes == 2'd2) ? 4'd1 : 4'd7))
          begin
            bitCnt  <= 4'd0;
            byteCnt <= byteCnt + 2'd1;
            if (byteCnt == 2'(`QFD_ADDR_BYTES - 1)) begin
              dmyCnt <= dummyOf(opc, quadLk, rpLk);
              phase  <= (dummyOf(opc, quadLk, rpLk) != 6'd0)
                        ? qfd_pkg::QFD_DMY : qfd_pkg::QFD_DAT;
            end
          end
        end
        qfd_pkg::QFD_DMY: begin
          bitCnt <= 4'd0;
          dmyCnt <= dmyCnt - 6'd1;
          if (dmyCnt == 6'd1) begin
            phase <= qfd_pkg::QFD_DAT;
          end
        end
        qfd_pkg::QFD_DAT: begin
          if (bitCnt == (fr.lanes == 2'd2 ? 4'd1 :
                         fr.lanes == 2'd1 ? 4'd3 : 4'd7)) begin
            bitCnt <= 4'd0;
            if (dataCnt != 2'd3) begin
              dataCnt <= dataCnt + 2'd1;
            end
          end
        end
        qfd_pkg::QFD_IGN: bitCnt <= 4'd0;
        default: phase <= qfd_pkg::QFD_IGN;
      endcase
    end
  end

  // incoming data bytes; only the first two are kept
  always_ff @(posedge linkClk) begin
    if (phase == qfd_pkg::QFD_DAT && fr.isWrite) begin
      dbyte <= fr.lanes == 2'd2 ? {dbyte[3:0], ioIn}
             : {dbyte[6:0], ioIn[0]};
      if (bitCnt == (fr.lanes == 2'd2 ? 4'd1 : 4'd7) && dataCnt < 2'd2)
      begin
        cmdData <= {cmdData[7:0],
                    fr.lanes == 2'd2 ? {dbyte[3:0], ioIn}
                                     : {dbyte[6:0], ioIn[0]}};
      end
    end
  end

  // byte to return; read streams repeat the last source byte
  always_comb begin
    unique case (opc)
      `QFD_OP_RDSR0:  outByte = stSync2[7:0];
      `QFD_OP_RDSR1:  outByte = stSync2[15:8];
      `QFD_OP_RDCR:   outByte = configReg;
      `QFD_OP_RELDPD: outByte = ELEC_ID;
      `QFD_OP_RDID:   outByte = dataCnt == 2'd0 ? MAKER_ID :
                                dataCnt == 2'd1 ? DEV_ID[15:8] :
                                DEV_ID[7:0];
      default:        outByte = 8'h00;  // array data is the core's
    endcase
  end

  // drive on falling edge; lane selection per width
  always_ff @(negedge linkClk or posedge csN) begin
    if (csN) begin
      ioOe  <= 4'h0;
      ioOut <= 4'h0;
    end else if (phase == qfd_pkg::QFD_DAT && fr.isRead) begin
      unique case (fr.lanes)
        2'd2: begin
          ioOe  <= 4'hF;
          ioOut <= bitCnt[0] ? outByte[3:0] : outByte[7:4];
        end
        2'd1: begin
          ioOe  <= 4'h3;
          ioOut <= {2'b00, outByte[3'(7 - 2 * bitCnt[1:0]) -: 2]};
        end
        default: begin
          ioOe  <= 4'h2;
          ioOut <= {2'b00, outByte[3'(7 - bitCnt[2:0])], 1'b0};
        end
      endcase
    end else begin
      ioOe <= 4'h0;
    end
  end

  // on deselect, hand the finished command to the core
  always_ff @(posedge csN) begin
    cmdValid <= phase == qfd_pkg::QFD_DAT || phase == qfd_pkg::QFD_DMY;
    cmdOpc   <= opc;
    cmdCnt   <= dataCnt;
  end

  // ****************************************
  // core domain
  // ****************************************
  logic [2:0]  csSync;                       // chip select synchroniser
  logic [7:0]  cOpc;                         // captured opcode
  logic [15:0] cData;                        // captured data
  logic [1:0]  cCnt;                         // captured count
  logic [23:0] cAddr;                        // captured address
  logic        cmdPulse;                     // one command finished
  logic        wrOk;                         // write accepted
  qfd_pkg::qfd_frame_s cFr;                  // framing of captured opcode

  // deselect ends a frame; the words it captured stand until the next one
  always_ff @(posedge clk) begin
    if (reset) begin
      csSync <= 3'h7;                        // idle high: no false edge
    end else begin
      csSync <= {csSync[1:0], csN};
    end
  end
  assign cmdPulse = csSync[1] & ~csSync[2] & cmdValid;

  // captured words stop changing at deselect, long before the next pulse
  always_ff @(posedge clk) begin
    cOpc  <= cmdOpc;
    cData <= cmdData;
    cCnt  <= cmdCnt;
    cAddr <= addr;
  end

  assign wrOk = writeEnableLatch | volatileArm;
  assign cFr  = frame(cOpc, 1'b0);
  // write latch and arming flags
  always_ff @(posedge clk) begin
    if (reset) begin
      writeEnableLatch <= 1'b0;
      volatileArm      <= 1'b0;
      rstArmed         <= 1'b0;
    end else if (cmdPulse) begin
      rstArmed <= (cOpc == `QFD_OP_RSTEN);
      if (cOpc == `QFD_OP_WRITE_ENABLE_COMMAND) begin
        writeEnableLatch <= 1'b1;
      end else if (cOpc == `QFD_OP_WRDI ||
                   (cOpc == `QFD_OP_RST && rstArmed)) begin
        writeEnableLatch <= 1'b0;
      end else if (writeEnableLatch && cFr.isWrite) begin
        writeEnableLatch <= 1'b0;
      end
      if (cOpc == `QFD_OP_VWREN) begin
        volatileArm <= 1'b1;
      end else if (cOpc == `QFD_OP_WRSR || cOpc == `QFD_OP_WRSR1) begin
        volatileArm <= 1'b0;
      end
    end
  end

  // status, configuration and read parameter writes
  always_ff @(posedge clk) begin
    if (reset) begin
      statusWr    <= 16'h0000;
      statusWrVal <= 1'b0;
      statusWrHi  <= 1'b0;
      configReg   <= `QFD_CFG_RESET;
      readParam   <= `QFD_RDP_RESET;
    end else begin
      statusWrVal <= 1'b0;
      if (cmdPulse && cCnt != 2'd0) begin
        if (cOpc == `QFD_OP_WRSR && wrOk) begin
          statusWr    <= cCnt == 2'd1 ? {statusIn[15:8], cData[7:0]}
                                      : {cData[7:0], cData[15:8]};
          statusWrHi  <= 1'b0;
          statusWrVal <= 1'b1;
        end else if (cOpc == `QFD_OP_WRSR1 && wrOk && cCnt == 2'd1) begin
          statusWr    <= {cData[7:0], statusIn[7:0]};
          statusWrHi  <= 1'b1;
          statusWrVal <= 1'b1;
        end else if (cOpc == `QFD_OP_WRCR && wrOk) begin
          configReg   <= cData[7:0];
        end else if (cOpc == `QFD_OP_SETRP) begin
          readParam   <= cData[7:0];
        end
      end
    end
  end

  // mode flags and command pulses toward the array core
  always_ff @(posedge clk) begin
    if (reset) begin
      quadMode <= 1'b0;
      evt      <= '0;
      cmdAddr  <= 24'h00_0000;
    end else begin
      evt <= '0;
      if (cmdPulse) begin
        cmdAddr        <= cAddr;
        evt.welSet     <= cOpc == `QFD_OP_WRITE_ENABLE_COMMAND;
        evt.welClr     <= cOpc == `QFD_OP_WRDI;
        evt.volArm     <= cOpc == `QFD_OP_VWREN;
        evt.blkLock    <= cOpc == `QFD_OP_BLK_LOCK && wrOk;
        evt.blkUnlock  <= cOpc == `QFD_OP_BLK_ULK && wrOk;
        evt.globLock   <= cOpc == `QFD_OP_GLOCK;
        evt.globUnlock <= cOpc == `QFD_OP_GULK;
        evt.eraseReq   <= wrOk && (cOpc == `QFD_OP_PGER ||
                          cOpc == `QFD_OP_SECER || cOpc == `QFD_OP_BE32 ||
                          cOpc == `QFD_OP_BE64);
        evt.bufClear   <= cOpc == `QFD_OP_BUFCLR;
        evt.bufLoad    <= cOpc == `QFD_OP_BUFLD;
        evt.bufProg    <= cOpc == `QFD_OP_BUFPP && wrOk;
        evt.dpdEnter   <= cOpc == `QFD_OP_DPD;
        evt.dpdLeave   <= cOpc == `QFD_OP_RELDPD;
        evt.quadExit   <= cOpc == `QFD_OP_EXITQ && quadMode;
        evt.softReset  <= cOpc == `QFD_OP_RST && rstArmed;
        if ((cOpc == `QFD_OP_EXITQ && quadMode) ||
            (cOpc == `QFD_OP_RST && rstArmed)) begin
          quadMode <= 1'b0;
        end
      end
      if (enterQuad) quadMode <= 1'b1; // a core request beats an exit
    end
  end
endmodule

// file: verification/qfd_decoder_monitor.sv
`timescale 1ns/1ps
// ****************************************
// port checker, all in the core clock domain
// ****************************************
module qfd_decoder_monitor (
  input wire logic              clk,              // core clock
  input wire logic              reset,            // sync reset, high
  input wire logic              csN,              // chip select, low
  input wire logic [3:0]        ioOe,             // io enables
  input wire logic              writeEnableLatch, // write latch
  input wire logic              volatileArm,      // volatile write armed
  input wire logic              quadMode,         // four wire mode
  input wire logic              statusWrVal,      // status write pulse
  input wire qfd_pkg::qfd_evt_s evt               // command pulses
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // a deselected device must leave every pin to the host
  idle_release_a: assert property ($past(csN) && csN |-> ioOe == 4'h0)
    else $error("io driven while deselected");
  evt_one_hot_a: assert property ($onehot0(evt))
    else $error("two command pulses at once");
  evt_pulse_a: assert property (|evt |=> evt == '0)
    else $error("command pulse longer than one cycle");
  wel_set_a: assert property (evt.welSet |-> ##[0:2] writeEnableLatch)
    else $error("write latch not set");
  wel_clear_a: assert property (evt.welClr |-> ##[0:2] !writeEnableLatch)
    else $error("write latch not cleared");
  arm_set_a: assert property (evt.volArm |-> ##[0:2] volatileArm)
    else $error("volatile write not armed");
  // erase and program are refused unless the write latch stood just before; the volatile arm alone fails this check
  erase_gate_a: assert property (evt.eraseReq || evt.bufProg |->
    $past(writeEnableLatch) || $past(writeEnableLatch, 2))
    else $error("erase or program without write latch");
  status_gate_a: assert property (statusWrVal |-> $past(writeEnableLatch) ||
    $past(volatileArm) || $past(writeEnableLatch, 2) || $past(volatileArm, 2))
    else $error("status write without enable");
  quad_exit_a: assert property (evt.quadExit |-> ##[0:2] !quadMode)
    else $error("four wire mode kept after exit");
  cover property (evt.eraseReq);
  cover property (evt.softReset);
  cover property ($fell(quadMode));
  cover property (statusWrVal);
endmodule
bind qfd_decoder qfd_decoder_monitor qfd_decoder_monitor_inst (
  .clk(clk), .reset(reset), .csN(csN), .ioOe(ioOe),
  .writeEnableLatch(writeEnableLatch), .volatileArm(volatileArm),
  .quadMode(quadMode), .statusWrVal(statusWrVal), .evt(evt)
);

// file: verification/qfd_host_model.sv
`timescale 1ns/1ps
// ****************************************
// host controller; link clock runs only inside frames
// ****************************************
module qfd_host_model (
  input  wire logic        go,      // start one frame
  input  wire logic        quad,    // nibble framing
  input  wire logic [31:0] txData,  // bytes, first one on top
  input  wire logic [2:0]  txBytes, // bytes to send
  input  wire logic        rdOne,   // read one byte after
  input  wire logic [3:0]  ioOut,   // device drive
  input  wire logic [3:0]  ioOe,    // device enables
  output logic             busy,    // frame running
  output logic [7:0]       rdByte,  // byte read back
  output logic             linkClk, // serial clock
  output logic             csN,     // chip select, low
  output logic [3:0]       ioIn     // resolved pin levels
);
  logic [3:0] hostDrv; // host drive, yields where the device drives
  int         i;       // bit position
  assign ioIn = (ioOe & ioOut) | (~ioOe & hostDrv);
  initial begin
    linkClk = 1'b0;
    csN     = 1'b0;
    busy    = 1'b0;
    rdByte  = 8'h00;
    hostDrv = 4'hF;
    #20 csN = 1'b1; // a first deselect clears the device's link side
  end
  // data changes after the falling edge; device samples on the rising one
  always @(posedge go) begin
    busy = 1'b1;
    #40 csN = 1'b0;
    for (i = 0; i < txBytes * 8; i += quad ? 4 : 1) begin
      if (quad) hostDrv = txData[31 - i -: 4];
      else hostDrv = {3'b111, txData[31 - i]};
      #62.5 linkClk = 1'b1;
      #62.5 linkClk = 1'b0;
    end
    // released lines must not keep showing the last bit
    hostDrv = quad ? ~hostDrv : hostDrv ^ 4'h1;
    for (i = 0; i < (rdOne ? 8 : 0); i += quad ? 4 : 1) begin
      #62.5 linkClk = 1'b1;
      rdByte = quad ? {rdByte[3:0], ioIn} : {rdByte[6:0], ioIn[1]};
      #62.5 linkClk = 1'b0;
    end
    #40 csN = 1'b1;
    #100 busy = 1'b0;
  end
endmodule

// file: verification/qfd_decoder_tb.sv
`timescale 1ns/1ps
module qfd_decoder_tb;
  // ****************************************
  // stimulus, host model and comparisons
  // ****************************************
  localparam logic [7:0] MAKER = 8'hC3; // arbitrary value
  logic              clk       = 1'b0;          // core clock
  logic              reset     = 1'b1;          // sync reset
  logic              enterQuad = 1'b0;          // core asks quad mode
  logic              go        = 1'b0;          // frame start
  logic              quad      = 1'b0;          // nibble framing
  logic              rdOne     = 1'b0;          // read a byte back
  logic              clrEvt    = 1'b0;          // clear event record
  logic [31:0]       txData    = 32'h0000_0000; // frame bytes
  logic [2:0]        txBytes   = 3'h1;          // frame length
  logic [15:0]       statusIn  = 16'h96E1;      // core status
  logic              linkClk, csN, busy, writeEnableLatch, quadMode;
  logic              volatileArm, statusWrVal, statusWrHi;
  logic [3:0]        ioIn, ioOut, ioOe;         // io pins
  logic [7:0]        rdByte, configReg, readParam;
  logic [15:0]       statusWr;                  // status write value
  logic [23:0]       cmdAddr;                   // command address
  qfd_pkg::qfd_evt_s evt, evtSeen;              // pulses, sticky copy
  int                numErrors  = 0;            // mismatches
  int                checksDone = 0;            // comparisons
  always #5 clk = ~clk;
  // pulses are one cycle wide, so keep a sticky record per frame
  always @(posedge clk) evtSeen <= clrEvt ? '0 : (evtSeen | evt);
  qfd_decoder #(.MAKER_ID(MAKER)) qfd_decoder_inst (
    .clk(clk), .reset(reset), .linkClk(linkClk), .csN(csN), .ioIn(ioIn),
    .ioOut(ioOut), .ioOe(ioOe), .statusIn(statusIn),
    .writeEnableLatch(writeEnableLatch), .quadMode(quadMode),
    .volatileArm(volatileArm), .statusWr(statusWr),
    .statusWrVal(statusWrVal), .statusWrHi(statusWrHi),
    .configReg(configReg), .readParam(readParam), .cmdAddr(cmdAddr),
    .evt(evt), .enterQuad(enterQuad));
  qfd_host_model qfd_host_model_inst (
    .go(go), .quad(quad), .txData(txData), .txBytes(txBytes),
    .rdOne(rdOne), .ioOut(ioOut), .ioOe(ioOe), .busy(busy),
    .rdByte(rdByte), .linkClk(linkClk), .csN(csN), .ioIn(ioIn));
  task automatic tally_and_finish;
    if (numErrors == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [23:0] seen, exp);
    checksDone++;
    if (seen !== exp) begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one frame; effects land within 8 cycles of deselect
  task automatic send(input logic q, input logic [31:0] d,
                      input logic [2:0] n, input logic r);
    int k;
    @(posedge clk);
    clrEvt  <= 1'b1;
    quad    <= q;
    txData  <= d;
    txBytes <= n;
    rdOne   <= r;
    go      <= 1'b1;
    @(posedge clk);
    clrEvt <= 1'b0;
    go     <= 1'b0;
    for (k = 0; busy && k < 2000; k++) @(posedge clk);
    if (k == 2000) begin
      numErrors++;
      tally_and_finish();
    end
    repeat (8) @(posedge clk);
  endtask
  // each entry: preceding opcode, opcode, address flag, expected pulse
  task automatic evt_table;
    logic [31:0] tbl [21] = '{32'h0406_4000, 32'h0604_2000, 32'h0050_1000,
      32'h0636_8800, 32'h0639_8400, 32'h067E_0200, 32'h0698_0100,
      32'h0681_8080, 32'h0620_8080, 32'h0652_8080, 32'h06D8_8080,
      32'h069E_0040, 32'h069A_8020, 32'h069D_8010, 32'h06B9_0008,
      32'h00AB_8004, 32'h0099_0000, 32'h6699_0001, 32'h003A_0000,
      32'h00FF_0000, 32'h000E_0000};
    foreach (tbl[k]) begin
      send(1'b0, {tbl[k][31:24], 24'h00_0000}, 3'h1, 1'b0);
      send(1'b0, {tbl[k][23:16], 24'h12_3456}, tbl[k][15] ? 3'h4 : 3'h1, 1'b0);
      check("evt", {9'h000, evtSeen}, {9'h000, tbl[k][14:0]});
      if (tbl[k][15] && tbl[k][14:0] != 15'h0000) begin
        check("cmdAddr", cmdAddr, 24'h12_3456);
      end
    end
  endtask
  task automatic status_ops;
    send(1'b0, 32'h0500_0000, 3'h1, 1'b1);
    check("status low", 24'(rdByte), 24'(statusIn[7:0]));
    send(1'b0, 32'h3500_0000, 3'h1, 1'b1);
    check("status high", 24'(rdByte), 24'(statusIn[15:8]));
    send(1'b0, 32'h0600_0000, 3'h1, 1'b0);
    check("wel", 24'(writeEnableLatch), 24'h1);
    send(1'b0, 32'h015A_C300, 3'h3, 1'b0);
    check("statusWr", 24'(statusWr), 24'h00_C35A);
    check("wel after", 24'(writeEnableLatch), 24'h0);
    send(1'b0, 32'h0600_0000, 3'h1, 1'b0);
    send(1'b0, 32'h3181_0000, 3'h2, 1'b0);
    check("statusWrHi", 24'(statusWrHi), 24'h1);
  endtask
  task automatic config_ops;
    send(1'b0, 32'h0600_0000, 3'h1, 1'b0);
    send(1'b0, 32'h113C_0000, 3'h2, 1'b0);
    check("configReg", 24'(configReg), 24'h3C);
    send(1'b0, 32'h1177_0000, 3'h2, 1'b0);
    check("config kept", 24'(configReg), 24'h3C);
    send(1'b0, 32'h1500_0000, 3'h1, 1'b1);
    check("config read", 24'(rdByte), 24'h3C);
  endtask
  task automatic quad_ops;
    @(posedge clk);
    enterQuad <= 1'b1;
    repeat (2) @(posedge clk);
    enterQuad <= 1'b0;
    repeat (4) @(posedge clk);
    check("quadMode", 24'(quadMode), 24'h1);
    send(1'b1, 32'h0600_0000, 3'h1, 1'b0);
    check("quad wel", 24'(writeEnableLatch), 24'h1);
    send(1'b1, 32'h0400_0000, 3'h1, 1'b0);
    check("quad wel off", 24'(writeEnableLatch), 24'h0);
    send(1'b1, 32'h5000_0000, 3'h1, 1'b0);
    check("arm", 24'(volatileArm), 24'h1);
    send(1'b1, 32'hC020_0000, 3'h2, 1'b0);
    check("readParam", 24'(readParam), 24'h20);
    send(1'b1, 32'h9F00_0000, 3'h1, 1'b1);
    check("maker", 24'(rdByte), 24'(MAKER));
    send(1'b1, 32'hFF00_0000, 3'h1, 1'b0);
    check("quad exit", 24'(quadMode), 24'h0);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    evt_table();
    status_ops();
    config_ops();
    quad_ops();
    tally_and_finish();
  end
endmodule
